// ===== bench/dam_front_model.sv
/*
 * Behavioural model of the measurement front end and the blocking source.
 * Assumes the bench sets the request inputs; every output follows aclk.
 */
`timescale 1ns/1ns
module dam_front_model (
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Requests from the bench
	input  wire logic [2:0][15:0] amp_req,
	input  wire logic [2:0][15:0] pwr_req,
	input  wire logic             blk_req,
	// Towards the sequencer
	output logic      [2:0][15:0] amp_o,
	output logic      [2:0][15:0] pwr_o,
	output logic                  blk_o,
	output logic      [31:0]      ts_o
);
	// The stamp steps once per clock so the bench can predict every value.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ts_o <= 32'h0;
		end else begin
			ts_o <= ts_o + 32'h1;
		end
	end
	// The bench raises blocking at least one program cycle before the delay ends.
	always_ff @(posedge aclk) begin
		blk_o <= blk_req;
		amp_o <= amp_req;
		pwr_o <= pwr_req;
	end
endmodule

// ===== bench/tb_top.sv
/*
 * Self-checking bench for the distortion alarm sequencer.
 * Assumes a short program cycle of 20 clocks and AXI4-Lite register access.
 */
`timescale 1ns/1ns
module tb_top;
	import dam_pkg::*;
	localparam int CYC = 20;
	localparam logic [7:0] RA [8] = '{REG_CTRL, REG_THR, REG_DLY, REG_MASK, REG_STAT,
		REG_CNT0, REG_CNT1, REG_LSEL};
	localparam logic [31:0] RV [8] = '{32'h11, 32'h3E8, 32'h7D0, 32'h3F, 32'h0, 32'h0,
		32'h0, 32'h0};
	logic             aclk;
	logic             aresetn;
	logic [7:0]       awaddr;
	logic [7:0]       araddr;
	logic [31:0]      wdata;
	logic             awvalid;
	logic             wvalid;
	logic             bready;
	logic             arvalid;
	logic             rready;
	wire logic        awready;
	wire logic        wready;
	wire logic        bvalid;
	wire logic        arready;
	wire logic        rvalid;
	wire logic [1:0]  bresp;
	wire logic [1:0]  rresp;
	wire logic [31:0] rdata;
	logic [2:0][15:0] amp_req;
	logic [2:0][15:0] pwr_req;
	logic             blk_req;
	wire logic [2:0][15:0] amp;
	wire logic [2:0][15:0] pwr;
	wire logic        blk;
	wire logic [31:0] ts;
	wire logic        start_q;
	wire logic        alarm_q;
	wire logic        blocked_q;
	wire logic [5:0]  evt_q;
	wire logic [31:0] evt_ts_q;
	int               bad_count;
	int               n_compared;
	logic [31:0]      lfsr_s;
	int               cnt [3];
	int               q_code [$];
	logic [31:0]      q_ts [$];
	logic [47:0]      q_ph [$];
	logic             pow_m;
	logic [5:0]       mask_m;
	logic [2:0]       prev;
	logic [2:0]       st;
	logic [5:0]       exp_evt;
	logic [31:0]      exp_ts;
	logic [47:0]      ph_prev;
	logic [31:0]      d;
	logic [1:0]       r;

	dam_front_model fe_u (.aclk(aclk), .aresetn(aresetn), .amp_req(amp_req), .pwr_req(pwr_req),
		.blk_req(blk_req), .amp_o(amp), .pwr_o(pwr), .blk_o(blk), .ts_o(ts));
	dam_seq #(.CYCLE_CLKS(CYC)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .amplitude_ratio_distortion(amp),
		.power_ratio_distortion(pwr), .block_in(blk), .ts_now(ts), .start_q(start_q),
		.alarm_q(alarm_q), .blocked_q(blocked_q), .evt_q(evt_q), .evt_ts_q(evt_ts_q));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic stv(input int i);
		logic [2:0] s;
		s = {blocked_q, alarm_q, start_q};
		return s[i];
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 200);
		bready <= 1'b0;
		chk("bresp", er, bresp);
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 200);
		v = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		logic [1:0] rr;
		axr(a, v, rr);
		chk(nm, e, v);
	endtask

	task automatic wait_st(input int i, input logic v, input int lim);
		int n;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (stv(i) !== v && n < lim);
		chk("status", v, stv(i));
	endtask

	// Phase k gets v; the others get noise well below the release level.
	task automatic set_ph(input int k, input logic [15:0] v, input logic pw);
		@(posedge aclk);
		for (int j = 0; j < 3; j++) begin
			lfsr_s = lfsr(lfsr_s);
			amp_req[j] <= (j == k && !pw) ? v : 16'(lfsr_s % 900);
			pwr_req[j] <= (j == k && pw) ? v : 16'(lfsr_s % 800);
		end
	endtask

	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Reference model: a status change and its event pulse land on the same edge.
	always @(negedge aclk) begin
		if (!aresetn) begin
			prev = 3'h0;
			exp_evt = 6'h0;
			exp_ts = ts;
			ph_prev = amp;
		end else begin
			st = {blocked_q, alarm_q, start_q};
			exp_evt = 6'h0;
			for (int i = 0; i < 3; i++) begin
				if (st[i] && !prev[i]) begin
					exp_evt[2*i] = 1'b1;
					if (cnt[i] < 65535) cnt[i]++;
					q_code.push_front(2 * i);
					q_ts.push_front(exp_ts);
					q_ph.push_front(ph_prev);
					if (q_code.size() > LOG_DEPTH) begin
						void'(q_code.pop_back());
						void'(q_ts.pop_back());
						void'(q_ph.pop_back());
					end
				end else if (!st[i] && prev[i]) begin
					exp_evt[2*i+1] = 1'b1;
				end
			end
			chk("evt_q", {2'h0, exp_evt & mask_m}, {2'h0, evt_q});
			if ((exp_evt & mask_m) != 6'h0) chk("evt_ts", exp_ts, evt_ts_q);
			if (start_q === 1'b1) chk("blocked_with_start", 32'h0, blocked_q);
			// Stamps and phases are captured from the cycle before the edge.
			exp_ts = ts;
			ph_prev = pow_m ? pwr : amp;
			prev = st;
		end
	end

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	initial begin
		repeat (30000) @(posedge aclk);
		bad_count++;
		final_report;
	end

	initial begin
		aresetn = 1'b0;
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
		amp_req = '0;
		pwr_req = '0;
		blk_req = 1'b0;
		bad_count = 0;
		n_compared = 0;
		lfsr_s = 32'h3E5A;
		cnt = '{0, 0, 0};
		pow_m = 1'b0;
		mask_m = 6'h3F;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 8; i++) rd_chk("reset_value", RA[i], RV[i]);
		axr(8'h34, d, r);
		chk("rresp", RESP_ERR, r);
		chk("rdata", 32'h0, d);
		axw(8'h34, 32'hFFFFFFFF, RESP_ERR);
		axw(REG_STAT, 32'hF, RESP_OK);
		rd_chk("stat", REG_STAT, 32'h0);
		axw(REG_DLY, 32'h7FFFF, RESP_OK);
		rd_chk("dly_clamp", REG_DLY, {13'h0, DLY_MAX});
		$display("test registers done");
		axw(REG_DLY, 32'h3, RESP_OK);
		set_ph(1, 16'h03E9, 1'b0);
		wait_st(0, 1'b1, 3 * CYC);
		repeat (2 * CYC) @(negedge aclk);
		chk("alarm_early", 32'h0, alarm_q);
		wait_st(1, 1'b1, 2 * CYC);
		set_ph(1, 16'h03D4, 1'b0);
		repeat (3 * CYC) @(negedge aclk);
		chk("start_hold", 32'h1, start_q);
		rd_chk("stat_run", REG_STAT, 32'hB);
		set_ph(1, 16'h03C0, 1'b0);
		wait_st(0, 1'b0, 3 * CYC);
		chk("alarm_clear", 32'h0, alarm_q);
		rd_chk("cnt_start", REG_CNT0, cnt[0]);
		rd_chk("cnt_alarm", REG_CNT1, cnt[1]);
		$display("test start and alarm done");
		@(posedge aclk);
		blk_req <= 1'b1;
		repeat (CYC) @(posedge aclk);
		set_ph(0, 16'h0500, 1'b0);
		wait_st(2, 1'b1, 3 * CYC);
		repeat (4 * CYC) @(negedge aclk);
		chk("start_blocked", 32'h0, start_q);
		chk("alarm_blocked", 32'h0, alarm_q);
		set_ph(0, 16'h0000, 1'b0);
		blk_req <= 1'b0;
		wait_st(2, 1'b0, 3 * CYC);
		set_ph(2, 16'h0500, 1'b0);
		wait_st(0, 1'b1, 3 * CYC);
		@(posedge aclk);
		blk_req <= 1'b1;
		wait_st(0, 1'b0, 2 * CYC);
		repeat (3 * CYC) @(negedge aclk);
		chk("alarm_after_block", 32'h0, alarm_q);
		set_ph(2, 16'h0000, 1'b0);
		blk_req <= 1'b0;
		wait_st(2, 1'b0, 3 * CYC);
		rd_chk("cnt_blocked", REG_CNT2, cnt[2]);
		$display("test blocking done");
		axw(REG_CTRL, 32'h13, RESP_OK);
		pow_m = 1'b1;
		for (int k = 0; k < 8; k++) begin
			set_ph(k % 3, 16'h0400 + 16'(k * 7), 1'b1);
			wait_st(0, 1'b1, 3 * CYC);
			set_ph(k % 3, 16'h0000, 1'b1);
			wait_st(0, 1'b0, 3 * CYC);
		end
		pow_m = 1'b0;
		rd_chk("fill", REG_LSEL, 32'(q_code.size()) << 8);
		for (int i = 0; i < q_code.size(); i++) begin
			axw(REG_LSEL, 32'(i), RESP_OK);
			rd_chk("rec_time", REG_LTIME, q_ts[i]);
			rd_chk("rec_info", REG_LINFO, 32'(q_code[i]) | 32'h10);
			rd_chk("rec_ph01", REG_LPH01, q_ph[i][31:0]);
			rd_chk("rec_ph2", REG_LPH2, {16'h0, q_ph[i][47:32]});
		end
		axw(REG_LSEL, 32'hC, RESP_OK);
		rd_chk("rec_empty", REG_LTIME, 32'h0);
		$display("test log done");
		axw(REG_CTRL, 32'h10, RESP_OK);
		set_ph(0, 16'h0600, 1'b0);
		repeat (3 * CYC) @(negedge aclk);
		chk("start_disabled", 32'h0, start_q);
		set_ph(0, 16'h0000, 1'b0);
		axw(REG_CTRL, 32'h11, RESP_OK);
		axw(REG_MASK, 32'h1, RESP_OK);
		mask_m = 6'h01;
		set_ph(0, 16'h0600, 1'b0);
		wait_st(0, 1'b1, 3 * CYC);
		set_ph(0, 16'h0000, 1'b0);
		wait_st(0, 1'b0, 3 * CYC);
		axw(REG_CTRL, 32'h111, RESP_OK);
		cnt = '{0, 0, 0};
		for (int i = 0; i < 3; i++) rd_chk("cnt_clear", REG_CNT0 + 8'(4 * i), 32'h0);
		$display("test mask and clear done");
		final_report;
	end
endmodule

// ===== verilog/dam_log.sv
/*
 * Circular record log; index 0 reads the newest record.
 * Assumes at most one write per clock from the sequencer.
 */
`timescale 1ns/1ns
module dam_log #(
	parameter int DEPTH = dam_pkg::LOG_DEPTH
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Sequencer side
	dam_log_if.log   lif
);
	import dam_pkg::*;

	dam_rec_t   mem_q [DEPTH];
	logic [3:0] wp_q;
	logic [3:0] fill_q;
	int         pos;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wp_q   <= 4'h0;
			fill_q <= 4'h0;
		end else if (lif.wr) begin
			// The oldest entry is overwritten once the log is full.
			wp_q <= (wp_q == 4'(DEPTH - 1)) ? 4'h0 : wp_q + 4'h1;
			if (fill_q != 4'(DEPTH))
				fill_q <= fill_q + 4'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (lif.wr)
			mem_q[wp_q] <= lif.wr_rec;
	end

	always_comb begin
		pos = int'(wp_q) - 1 - int'(lif.rd_idx);
		if (pos < 0)
			pos = pos + DEPTH;
		if (lif.rd_idx < fill_q)
			lif.rd_rec = mem_q[pos];
		else
			lif.rd_rec = '0;
	end

	assign lif.fill = fill_q;

	a_log_fill_cap: assert property (@(posedge aclk) disable iff (!aresetn)
		fill_q == 4'(DEPTH) && lif.wr |=> fill_q == 4'(DEPTH) && wp_q != $past(wp_q))
		else $error("log fill or pointer wrong when full");
endmodule

// ===== verilog/dam_log_if.sv
/*
 * Link between the sequencer and its record log.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface dam_log_if;
	import dam_pkg::*;
	logic     wr;
	dam_rec_t wr_rec;
	logic [3:0] rd_idx;
	dam_rec_t rd_rec;
	logic [3:0] fill;
	modport seq (output wr, wr_rec, rd_idx, input rd_rec, fill);
	modport log (input wr, wr_rec, rd_idx, output rd_rec, fill);
endinterface

// ===== verilog/dam_pkg.sv
/*
 * Constants and types for the distortion alarm sequencer.
 * Assumes a 10 MHz clock; every other file except the front end model imports this package.
 */
package dam_pkg;
	// Timing, in the unit as given, then derived clock counts.
	localparam int CLK_NS      = 100;
	localparam int CYCLE_MS    = 5;
	localparam int CYCLE_CLKS  = CYCLE_MS * 1000000 / CLK_NS;
	localparam int BLK_LEAD_MS = 5;
	localparam int DLY_STEP_MS = 5;
	localparam int DLY_MAX_MS  = 1800000;
	localparam int DLY_DEF_MS  = 10000;
	localparam int DLY_W       = 19;
	localparam logic [DLY_W-1:0] DLY_MAX = DLY_W'(DLY_MAX_MS / DLY_STEP_MS);
	localparam logic [DLY_W-1:0] DLY_DEF = DLY_W'(DLY_DEF_MS / DLY_STEP_MS);
	localparam int HYST_PCT    = 97;
	localparam int LOG_DEPTH   = 12;
	localparam int CNT_W       = 16;

	// Register byte offsets.
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_THR    = 8'h04;
	localparam logic [7:0] REG_DLY    = 8'h08;
	localparam logic [7:0] REG_MASK   = 8'h0C;
	localparam logic [7:0] REG_STAT   = 8'h10;
	localparam logic [7:0] REG_CNT0   = 8'h14;
	localparam logic [7:0] REG_CNT1   = 8'h18;
	localparam logic [7:0] REG_CNT2   = 8'h1C;
	localparam logic [7:0] REG_LSEL   = 8'h20;
	localparam logic [7:0] REG_LTIME  = 8'h24;
	localparam logic [7:0] REG_LINFO  = 8'h28;
	localparam logic [7:0] REG_LPH01  = 8'h2C;
	localparam logic [7:0] REG_LPH2   = 8'h30;

	// Control fields and reset values.
	localparam int CTRL_EN_B   = 0;
	localparam int CTRL_POW_B  = 1;
	localparam int CTRL_GRP_L  = 4;
	localparam int CTRL_CLR_B  = 8;
	localparam logic        EN_RST   = 1'b1;
	localparam logic        POW_RST  = 1'b0;
	localparam logic [2:0]  GRP_RST  = 3'h1;
	localparam logic [15:0] THR_RST  = 16'h03E8;
	localparam logic [5:0]  MASK_RST = 6'h3F;
	localparam logic [1:0]  RESP_OK  = 2'h0;
	localparam logic [1:0]  RESP_ERR = 2'h2;

	typedef enum logic [2:0] {
		EV_START_ON, EV_START_OFF, EV_ALARM_ON,
		EV_ALARM_OFF, EV_BLK_ON, EV_BLK_OFF
	} dam_ev_t;

	typedef enum logic [1:0] {ST_NORMAL, ST_START, ST_ALARM, ST_BLOCKED} dam_state_t;

	typedef struct packed {
		logic [31:0]      ts;
		dam_ev_t          ev;
		logic [2:0]       grp;
		logic [2:0][15:0] ph;
	} dam_rec_t;
endpackage

// ===== verilog/dam_seq.sv
/*
 * Distortion alarm sequencer with AXI4-Lite registers, event pulses,
 * saturating counters and a twelve-record log.
 * Assumes distortion inputs and the time stamp come from logic on aclk,
 * in units of 0.01 %; the blocking input is asynchronous.
 */
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
// Function
// - Blocking input is sampled once per program cycle before pick-up evaluation.
// - Pick-up active and not blocked: assert start, begin alarm delay.
// - Pick-up active while blocked: assert blocked, no start or alarm.
// - Blocking after start drops start with normal release handling.
// - Definite alarm delay up to 1800 s in 5 ms steps, default 10 s.
// - Each event kind separately selects storing of ON, OFF or both; mask_q here gates only the evt_q pulses, the log keeps ON records unmasked.
// - Every event carries the time stamp of its status change.
// - Separate start, alarm, blocked counters, cleared by a request.
// - Six events: ON and OFF for start, alarm and blocked.
// - Circular log keeps the twelve newest records, oldest overwritten.
// - Log record on ON of start, alarm, blocked: time, event, group.
// - Record also holds the three phase distortion values.
// - Pick-up when any phase exceeds the threshold, only while enabled.
// - Pick-up releases only below 97 % of the threshold.
// - One static setting selects amplitude or power ratio for all phases.
`timescale 1ns/1ns
module dam_seq #(
	parameter int CYCLE_CLKS = dam_pkg::CYCLE_CLKS,
	parameter int DEPTH      = dam_pkg::LOG_DEPTH
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output wire logic              s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output wire logic              s_axi_wready,
	output wire logic [1:0]        s_axi_bresp,
	output wire logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output wire logic              s_axi_arready,
	output wire logic [31:0]       s_axi_rdata,
	output wire logic [1:0]        s_axi_rresp,
	output wire logic              s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Measurement front end, blocking and time
	input  wire logic [2:0][15:0]  amplitude_ratio_distortion,
	input  wire logic [2:0][15:0]  power_ratio_distortion,
	input  wire logic              block_in,
	input  wire logic [31:0]       ts_now,
	// Status outputs and event pulses
	output logic                   start_q,
	output logic                   alarm_q,
	output logic                   blocked_q,
	output logic [5:0]             evt_q,
	output logic [31:0]            evt_ts_q
);
	import dam_pkg::*;

	dam_log_if lif ();

	dam_log #(.DEPTH(DEPTH)) u_log (
		.aclk    (aclk),
		.aresetn (aresetn),
		.lif     (lif.log)
	);

	logic             awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic             rd_pend_q;
	logic [1:0]       bresp_q, rresp_q;
	logic [7:0]       awaddr_q, araddr_q;
	logic [31:0]      wdata_q, rdata_q, rmux, wcur, wmrg;
	logic [3:0]       wstrb_q;
	logic             rhit;
	logic             en_q, pow_q, pick_q, pick_d, tick_q;
	logic [2:0]       grp_q;
	logic [15:0]      thr_q;
	logic [DLY_W-1:0] dly_q, tmr_q, tmr_d;
	logic [5:0]       mask_q, edg;
	logic [3:0]       lsel_q;
	logic [31:0]      div_q;
	logic             blk_m_q, blk_s_q;
	logic             do_wr, cnt_clr, over, under;
	logic [2:0][15:0] ph;
	logic [2:0]       st_new;
	logic [CNT_W-1:0] cnt_q [3];
	logic             wr_q;
	dam_rec_t         rec_q;
	dam_state_t       state_q, state_d;

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (s[i])
				r[8*i +: 8] = d[8*i +: 8];
		return r;
	endfunction

	// Write channel: address and data are taken in either order.
	assign do_wr   = !awready_q && !wready_q && !bvalid_q;
	assign cnt_clr = do_wr && awaddr_q == REG_CTRL && wstrb_q[1] && wdata_q[CTRL_CLR_B];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OK;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end else begin
			if (awready_q && s_axi_awvalid) begin
				awaddr_q  <= s_axi_awaddr;
				awready_q <= 1'b0;
			end
			if (wready_q && s_axi_wvalid) begin
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
				wready_q <= 1'b0;
			end
			if (do_wr) begin
				bvalid_q <= 1'b1;
				bresp_q  <= (awaddr_q > REG_LPH2 || awaddr_q[1:0] != 2'h0) ? RESP_ERR : RESP_OK;
			end
			if (bvalid_q && s_axi_bready) begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	// Byte lanes merge into the register's present value.
	always_comb begin
		unique case (awaddr_q)
			REG_CTRL: wcur = {25'h0, grp_q, 2'h0, pow_q, en_q};
			REG_THR:  wcur = {16'h0, thr_q};
			REG_DLY:  wcur = {13'h0, dly_q};
			REG_MASK: wcur = {26'h0, mask_q};
			REG_LSEL: wcur = {28'h0, lsel_q};
			default:  wcur = 32'h0000_0000;
		endcase
		wmrg = merge(wcur, wdata_q, wstrb_q);
	end

	// Settings; read-only offsets ignore writes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_q   <= EN_RST;
			pow_q  <= POW_RST;
			grp_q  <= GRP_RST;
			thr_q  <= THR_RST;
			dly_q  <= DLY_DEF;
			mask_q <= MASK_RST;
			lsel_q <= 4'h0;
		end else if (do_wr) begin
			unique case (awaddr_q)
				REG_CTRL: begin
					en_q  <= wmrg[CTRL_EN_B];
					pow_q <= wmrg[CTRL_POW_B];
					grp_q <= wmrg[CTRL_GRP_L +: 3];
				end
				REG_THR:  thr_q <= wmrg[15:0];
				REG_DLY: begin
					// Delays beyond the longest setting are held at the longest.
					if (wmrg > {13'h0, DLY_MAX})
						dly_q <= DLY_MAX;
					else
						dly_q <= wmrg[DLY_W-1:0];
				end
				REG_MASK: mask_q <= wmrg[5:0];
				REG_LSEL: lsel_q <= wmrg[3:0];
				default:  ;
			endcase
		end
	end

	// Read channel: one cycle of decode after the address is taken.
	assign lif.rd_idx = lsel_q;

	always_comb begin
		rmux = 32'h0000_0000;
		rhit = 1'b1;
		unique case (araddr_q)
			REG_CTRL:  rmux = {25'h0, grp_q, 2'h0, pow_q, en_q};
			REG_THR:   rmux = {16'h0, thr_q};
			REG_DLY:   rmux = {13'h0, dly_q};
			REG_MASK:  rmux = {26'h0, mask_q};
			REG_STAT:  rmux = {28'h0, pick_q, blocked_q, alarm_q, start_q};
			REG_CNT0:  rmux = {16'h0, cnt_q[0]};
			REG_CNT1:  rmux = {16'h0, cnt_q[1]};
			REG_CNT2:  rmux = {16'h0, cnt_q[2]};
			REG_LSEL:  rmux = {20'h0, lif.fill, 4'h0, lsel_q};
			REG_LTIME: rmux = lif.rd_rec.ts;
			REG_LINFO: rmux = {24'h0, 1'b0, lif.rd_rec.grp, 1'b0, lif.rd_rec.ev};
			REG_LPH01: rmux = {lif.rd_rec.ph[1], lif.rd_rec.ph[0]};
			REG_LPH2:  rmux = {16'h0, lif.rd_rec.ph[2]};
			default:   rhit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rd_pend_q <= 1'b0;
			rvalid_q  <= 1'b0;
			araddr_q  <= 8'h00;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= RESP_OK;
		end else begin
			if (arready_q && s_axi_arvalid) begin
				araddr_q  <= s_axi_araddr;
				arready_q <= 1'b0;
				rd_pend_q <= 1'b1;
			end
			if (rd_pend_q) begin
				rd_pend_q <= 1'b0;
				rvalid_q  <= 1'b1;
				rdata_q   <= rmux;
				rresp_q   <= rhit ? RESP_OK : RESP_ERR;
			end
			if (rvalid_q && s_axi_rready) begin
				rvalid_q  <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	// Program cycle divider and blocking input synchroniser.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_q  <= 32'h0000_0000;
			tick_q <= 1'b0;
		end else begin
			tick_q <= div_q == 32'(CYCLE_CLKS - 1);
			div_q  <= (div_q == 32'(CYCLE_CLKS - 1)) ? 32'h0000_0000 : div_q + 32'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			blk_m_q <= 1'b0;
			blk_s_q <= 1'b0;
		end else begin
			blk_m_q <= block_in;
			blk_s_q <= blk_m_q;
		end
	end

	// Pick-up with a fixed 97 % release ratio against the common threshold.
	assign ph = pow_q ? power_ratio_distortion : amplitude_ratio_distortion;

	always_comb begin
		over  = 1'b0;
		under = 1'b1;
		for (int i = 0; i < 3; i++) begin
			if (ph[i] > thr_q)
				over = 1'b1;
			if (32'(ph[i]) * 32'd100 >= 32'(thr_q) * 32'(HYST_PCT))
				under = 1'b0;
		end
		if (!en_q)
			pick_d = 1'b0;
		else if (over)
			pick_d = 1'b1;
		else if (under)
			pick_d = 1'b0;
		else
			pick_d = pick_q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			pick_q <= 1'b0;
		else if (tick_q)
			pick_q <= pick_d;
	end

	// Sequencer: blocking is the value sampled at this program cycle's start.
	always_comb begin
		state_d = state_q;
		tmr_d   = tmr_q;
		if (tick_q) begin
			unique case (state_q)
				ST_NORMAL: if (pick_d) begin
					state_d = blk_s_q ? ST_BLOCKED : ST_START;
					tmr_d   = '0;
				end
				ST_START, ST_ALARM: if (!pick_d || blk_s_q) begin
					// Late blocking drops start and alarm like a dropped pick-up, but goes to blocked while pick-up holds.
					state_d = pick_d ? ST_BLOCKED : ST_NORMAL;
				end else if (state_q == ST_START) begin
					tmr_d = tmr_q + 1'b1;
					if (tmr_d >= dly_q)
						state_d = ST_ALARM;
				end
				ST_BLOCKED: if (!pick_d)
					state_d = ST_NORMAL;
			endcase
		end
	end

	assign st_new = {state_d == ST_BLOCKED, state_d == ST_ALARM,
		state_d == ST_START || state_d == ST_ALARM};
	assign edg = {!st_new[2] & blocked_q, st_new[2] & !blocked_q,
		!st_new[1] & alarm_q, st_new[1] & !alarm_q,
		!st_new[0] & start_q, st_new[0] & !start_q};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q   <= ST_NORMAL;
			tmr_q     <= '0;
			start_q   <= 1'b0;
			alarm_q   <= 1'b0;
			blocked_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			tmr_q     <= tmr_d;
			start_q   <= st_new[0];
			alarm_q   <= st_new[1];
			blocked_q <= st_new[2];
		end
	end

	// Event pulses, filtered per event, stamped with the change time.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt_q    <= 6'h00;
			evt_ts_q <= 32'h0000_0000;
		end else begin
			evt_q <= edg & mask_q;
			if (|edg)
				evt_ts_q <= ts_now;
		end
	end

	// Counters; a rise in the clearing cycle still counts.
	for (genvar g = 0; g < 3; g++) begin : g_cnt
		always_ff @(posedge aclk) begin
			if (!aresetn)
				cnt_q[g] <= '0;
			else if (edg[2*g])
				cnt_q[g] <= cnt_clr ? CNT_W'(1) : cnt_q[g] + CNT_W'(&cnt_q[g] ? 0 : 1);
			else if (cnt_clr)
				cnt_q[g] <= '0;
		end
	end

	// Log record on ON transitions only.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_q  <= 1'b0;
			rec_q <= '0;
		end else begin
			wr_q <= edg[EV_START_ON] | edg[EV_ALARM_ON] | edg[EV_BLK_ON];
			rec_q.ts  <= ts_now;
			rec_q.grp <= grp_q;
			rec_q.ph  <= ph;
			rec_q.ev  <= edg[EV_ALARM_ON] ? EV_ALARM_ON :
				edg[EV_START_ON] ? EV_START_ON : EV_BLK_ON;
		end
	end

	assign lif.wr     = wr_q;
	assign lif.wr_rec = rec_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_start_rise;
		!start_q ##1 start_q;
	endsequence

	sequence s_idle_pick(logic b);
		tick_q && state_q == ST_NORMAL && pick_d && blk_s_q == b;
	endsequence

	a_state_on_tick: assert property ($changed(state_q) |-> $past(tick_q))
		else $error("state moved outside a program cycle");
	a_start_begin: assert property (s_idle_pick(1'b0) |=> start_q && !blocked_q && tmr_q == 0)
		else $error("start not raised on unblocked pick-up");
	a_blocked_begin: assert property (s_idle_pick(1'b1) |=> (blocked_q && !start_q) [*2])
		else $error("blocked not raised on blocked pick-up");
	a_late_block: assert property (tick_q && start_q && blk_s_q |=> !start_q && !alarm_q)
		else $error("late blocking did not drop start");
	a_alarm_delay: assert property ($rose(alarm_q) |-> start_q && tmr_q >= dly_q
		&& $past(tmr_q) < dly_q || dly_q == 0)
		else $error("alarm raised before delay elapsed");
	a_alarm_needs_start: assert property (alarm_q |-> start_q)
		else $error("alarm active without start");
	a_evt_filter: assert property ($rose(start_q) ##0 $past(mask_q[0]) |-> evt_q[0]
		&& evt_ts_q == $past(ts_now))
		else $error("start ON event lost or wrongly stamped");
	a_cnt_step: assert property (s_start_rise ##0 !$past(cnt_clr)
		&& $past(cnt_q[0]) != {CNT_W{1'b1}}
		|-> cnt_q[0] == $past(cnt_q[0]) + 1'b1)
		else $error("start counter did not step once");
	a_cnt_clear: assert property (cnt_clr && !edg[4] |=> cnt_q[2] == 0)
		else $error("blocked counter not cleared");
	a_log_on_only: assert property ($fell(blocked_q) && !$rose(start_q) |-> !wr_q)
		else $error("log written on an OFF change");
	a_pick_enable: assert property (tick_q && !en_q |=> !pick_q)
		else $error("pick-up active while disabled");
	a_hysteresis: assert property (tick_q && pick_q && en_q && !over && !under |=> pick_q)
		else $error("pick-up released inside hysteresis band");
endmodule
